//--- vei_params.svh
// constants for the vector and external interrupt block
`ifndef VEI_PARAMS_SVH
`define VEI_PARAMS_SVH
`define VEI_VEC_RESET   4'h0
`define VEI_VEC_EXT     4'h1
`define VEI_VEC_PCHG    4'h2
`define VEI_VEC_TCAPT   4'h3
`define VEI_VEC_TOVF    4'h4
`define VEI_VEC_TCMPA   4'h5
`define VEI_VEC_TCMPB   4'h6
`define VEI_VEC_ACMP    4'h7
`define VEI_VEC_WDT     4'h8
`define VEI_VEC_SLM     4'h9
`define VEI_VEC_CONV    4'hA
`define VEI_NUM_PCHG    4
`define VEI_SRC_TIMER   0
`define VEI_SRC_ACMP    4
`define VEI_SRC_WDT     5
`define VEI_SRC_SLM     6
`define VEI_SRC_CONV    7
`endif

//--- vei_pkg.sv
// types for the vector and external interrupt block
package vei_pkg;
   typedef enum logic [1:0] {
      VEI_SENSE_LOW  = 2'b00,
      VEI_SENSE_ANY  = 2'b01,
      VEI_SENSE_FALL = 2'b10,
      VEI_SENSE_RISE = 2'b11
   } vei_sense_e;
   typedef logic [3:0] vei_vec_t;
endpackage

//--- vei_pchg_if.sv
// carrier between pin-change detector and vector logic
`timescale 1ns/10ps
interface vei_pchg_if;
   logic       pin_change_request;
   logic       wake;
   modport det (output pin_change_request, output wake);
   modport ctl (input pin_change_request, input wake);
endinterface

//--- vei_pchg_det.sv
// pin-change detector with clocked and asynchronous paths
`timescale 1ns/10ps
`include "vei_params.svh"
module vei_pchg_det
   import vei_pkg::*;
#(
   parameter int N = `VEI_NUM_PCHG
) (
   input  wire logic         i_mclk,
   input  wire logic         i_rst_n,
   input  wire logic         i_ce,
   input  wire logic [N-1:0] i_pins,
   input  wire logic [N-1:0] i_mask,
   vei_pchg_if.det           pc
);
   typedef struct packed {
      logic [N-1:0] s1;
      logic [N-1:0] s2;
      logic [N-1:0] s3;
      logic         req;
   } vei_pcd_s;
   vei_pcd_s st_q, st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = i_pins;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.req = |((st_q.s2 ^ st_q.s3) & i_mask);
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   assign pc.pin_change_request = st_q.req;
   // clockless wake path
   // last synchronised sample is the reference; the compare itself needs no clock
   assign pc.wake = |((i_pins ^ st_q.s3) & i_mask);

   AST_PC_REQ: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && |((st_q.s2 ^ st_q.s3) & i_mask) |=> st_q.req)
      else $error("masked toggle gave no request");
   AST_PC_MASK: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
      i_ce && ((st_q.s2 ^ st_q.s3) & i_mask) == '0 |=> !st_q.req)
      else $error("request without masked toggle");
endmodule

//--- vei_ctrl.sv
// vector and external interrupt controller top
`timescale 1ns/10ps
`include "vei_params.svh"
module vei_ctrl
   import vei_pkg::*;
#(
   parameter int  N_PC     = `VEI_NUM_PCHG,
   parameter bit  HAS_CONV = 1'b1
) (
   // clock, reset, enable
   input  wire logic            i_mclk,
   input  wire logic            i_rst_n,
   input  wire logic            i_ce,
   // pins (read from pad, whatever the direction)
   input  wire logic            i_ext_irq_pin,
   input  wire logic [N_PC-1:0] i_pin_change_inputs,
   // configuration
   input  wire logic            i_sense_select_hi,
   input  wire logic            i_sense_select_lo,
   input  wire logic            i_ext_irq_mask,
   input  wire logic            i_pin_change_enable,
   input  wire logic [N_PC-1:0] i_pin_change_mask,
   input  wire logic            i_global_ie,
   // flag clears by writing one
   input  wire logic            i_ext_irq_flag_clr,
   input  wire logic            i_pin_change_flag_clr,
   // other sources: capt, ovf, cmpa, cmpb, acmp, wdt, monitor, converter
   input  wire logic [7:0]      i_other_req,
   // core handshake
   input  wire logic            i_any_reset,
   input  wire logic            i_vector_ack,
   input  wire logic            i_sleeping,
   input  wire logic            i_startup_done,
   // outputs
   output logic                 o_irq_req,
   output vei_vec_t             o_vector,
   output logic                 o_ext_irq_flag,
   output logic                 o_pin_change_flag,
   output logic                 o_wake
);
   typedef struct packed {
      logic [2:0] es;
      logic       ext_irq_flag;
      logic       pin_change_flag;
      logic       irq;
      vei_vec_t   vec;
      logic       wake;
      logic       lvl_ok;
   } vei_ctl_s;

   vei_ctl_s   st_q, st_d;
   vei_sense_e sense;
   logic       ext_edge;
   logic       lvl_req;
   logic       async_low;
   logic [10:0] pend;
   vei_pchg_if pcif ();

   vei_pchg_det #(.N(N_PC)) u_pchg (
      .i_mclk  (i_mclk),
      .i_rst_n (i_rst_n),
      .i_ce    (i_ce),
      .i_pins  (i_pin_change_inputs),
      .i_mask  (i_pin_change_mask),
      .pc      (pcif.det)
   );

   // lowest set index among bits 1 to 10 of a pending vector bitmap, else vector zero
   function automatic vei_vec_t lowest(input logic [10:0] p);
      vei_vec_t r;
      r = `VEI_VEC_RESET;
      for (int i = 10; i >= 1; i--) begin
         if (p[i]) begin
            r = 4'(i);
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // sense decode
   assign sense = vei_sense_e'({i_sense_select_hi, i_sense_select_lo});
   // async low detect for wake, no clock used
   assign async_low = !i_ext_irq_pin && (sense == VEI_SENSE_LOW) && i_ext_irq_mask;

   always_comb begin
      ext_edge = 1'b0;
      // edge detect on synchronised, clocked samples
      unique case (sense)
         VEI_SENSE_LOW:  ext_edge = 1'b0;
         VEI_SENSE_ANY:  ext_edge = st_q.es[1] ^ st_q.es[2];
         VEI_SENSE_FALL: ext_edge = !st_q.es[1] && st_q.es[2];
         VEI_SENSE_RISE: ext_edge = st_q.es[1] && !st_q.es[2];
      endcase
   end

   // level request only once start-up done and still low
   assign lvl_req = (sense == VEI_SENSE_LOW) && !st_q.es[1] && st_q.lvl_ok;

   always_comb begin
      pend = '0;
      // external gated by mask and global enable
      pend[`VEI_VEC_EXT] = i_global_ie && i_ext_irq_mask
                           && (st_q.ext_irq_flag || lvl_req);
      // pin change gated by enable and global enable
      pend[`VEI_VEC_PCHG] = i_global_ie && i_pin_change_enable && st_q.pin_change_flag;
      pend[`VEI_VEC_TCAPT +: 4] = i_global_ie ? i_other_req[`VEI_SRC_TIMER +: 4] : 4'h0;
      pend[`VEI_VEC_ACMP] = i_global_ie && i_other_req[`VEI_SRC_ACMP];
      pend[`VEI_VEC_WDT]  = i_global_ie && i_other_req[`VEI_SRC_WDT];
      pend[`VEI_VEC_SLM]  = i_global_ie && i_other_req[`VEI_SRC_SLM];
      pend[`VEI_VEC_CONV] = i_global_ie && HAS_CONV && i_other_req[`VEI_SRC_CONV];
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      st_d.es = {st_q.es[1:0], i_ext_irq_pin};
      // set beats clear; never set in level mode
      if (sense == VEI_SENSE_LOW) begin
         st_d.ext_irq_flag = 1'b0;
      end else if (ext_edge) begin
         st_d.ext_irq_flag = 1'b1;
      end else if (i_ext_irq_flag_clr ||
                   (i_vector_ack && st_q.irq && st_q.vec == `VEI_VEC_EXT)) begin
         st_d.ext_irq_flag = 1'b0;
      end
      if (pcif.pin_change_request) begin
         st_d.pin_change_flag = 1'b1;
      end else if (i_pin_change_flag_clr ||
                   (i_vector_ack && st_q.irq && st_q.vec == `VEI_VEC_PCHG)) begin
         st_d.pin_change_flag = 1'b0;
      end
      // level honoured only after start-up completes
      if (i_sleeping || !i_startup_done) begin
         st_d.lvl_ok = 1'b0;
      end else begin
         st_d.lvl_ok = 1'b1;
      end
      // wake output, no interrupt by itself
      st_d.wake = i_sleeping && (async_low || pcif.wake || st_q.pin_change_flag);
      if (i_any_reset) begin
         st_d.irq = 1'b0;
         st_d.vec = `VEI_VEC_RESET;
      end else begin
         st_d.irq = |pend && !i_vector_ack;
         st_d.vec = lowest(pend);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= '{es: 3'b111, default: '0};
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   assign o_irq_req         = st_q.irq;
   assign o_vector          = st_q.vec;
   assign o_ext_irq_flag    = st_q.ext_irq_flag;
   assign o_pin_change_flag = st_q.pin_change_flag;
   assign o_wake            = st_q.wake;

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   AST_RESET_VEC: assert property (i_ce && i_any_reset |=> o_vector == 4'h0 && !o_irq_req)
      else $error("reset did not select vector zero");
   AST_EXT_VEC: assert property (i_ce && !i_any_reset && pend[1] |=> o_vector == 4'h1)
      else $error("external vector wrong");
   AST_PRIO: assert property (i_ce && !i_any_reset && pend[2] && !pend[1]
      |=> o_vector == 4'h2)
      else $error("priority wrong");
   AST_TIMER: assert property (i_ce && !i_any_reset && pend[6:1] == 6'b100000
      |=> o_vector == 4'h6)
      else $error("compare b vector wrong");
   AST_CONV: assert property (i_ce && !i_any_reset && pend == 11'h400
      |=> o_vector == 4'hA)
      else $error("converter vector wrong");
   AST_LVL_FLAG: assert property (i_ce && sense == VEI_SENSE_LOW |=> !o_ext_irq_flag)
      else $error("flag set in level mode");
   AST_FALL: assert property (i_ce && sense == VEI_SENSE_FALL && !st_q.es[1]
      && st_q.es[2] |=> o_ext_irq_flag)
      else $error("falling edge missed");
   AST_LVL_REQ: assert property (i_ce && !i_any_reset && !i_vector_ack && i_global_ie
      && i_ext_irq_mask && lvl_req |=> o_irq_req && o_vector == 4'h1)
      else $error("held low level gave no request");
   AST_ACK_CLR: assert property (i_ce && i_vector_ack && o_irq_req && o_vector == 4'h1
      && !ext_edge |=> !o_ext_irq_flag)
      else $error("vector execution left external flag set");
   AST_WAKE_AWAKE: assert property (i_ce && !i_sleeping |=> !o_wake)
      else $error("wake raised while awake");
   AST_NO_GIE: assert property (i_ce && !i_global_ie |=> !o_irq_req)
      else $error("request without global enable");
   AST_PC_SET: assert property (i_ce && pcif.pin_change_request |=> o_pin_change_flag)
      else $error("pin change flag not set");
   AST_FREEZE: assert property (!i_ce |=> $stable(st_q))
      else $error("state moved while disabled");

   COV_EXT: cover property (o_irq_req && o_vector == 4'h1);
   COV_PC: cover property (o_irq_req && o_vector == 4'h2);
   COV_WAKE: cover property (o_wake);
   COV_LVL: cover property (o_irq_req && o_vector == 4'h1 && sense == VEI_SENSE_LOW);
endmodule

//--- vei_core_model.sv
// core model that takes presented vectors and counts them
`timescale 1ns/10ps
module vei_core_model
   import vei_pkg::*;
(
   // control and design side
   input  wire logic      i_mclk,
   input  wire logic      i_ack_en,
   input  wire logic      i_irq_req,
   input  wire vei_vec_t  i_vector,
   // handshake and record
   output logic           o_ack,
   output vei_vec_t       o_last_vec,
   output logic [7:0]     o_acks
);
   initial begin
      o_ack = 1'b0;
      o_last_vec = 4'h0;
      o_acks = 8'h00;
   end
   // taken only when requested
   // gap cycle after each ack, as the core needs a cycle to vector
   // acts on the rising edge so it never races the bench's falling-edge stimulus
   always @(posedge i_mclk) begin
      o_ack <= i_ack_en & i_irq_req & ~o_ack;
      if (i_ack_en & i_irq_req & ~o_ack) begin
         o_last_vec <= i_vector;
         o_acks <= o_acks + 8'h01;
      end
   end
endmodule

//--- vei_ctrl_tb_top.sv
// self-checking bench for the vector and external interrupt block
`timescale 1ns/10ps
`include "vei_params.svh"
module vei_ctrl_tb_top;
   import vei_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, ext = 1'b1, emask = 1'b0, pcen = 1'b0;
   logic       gie = 1'b0, eclr = 1'b0, pclr = 1'b0, anyr = 1'b0, slp = 1'b0;
   logic       ack_en = 1'b0, ack, irq, ef, pf, wake, ce = 1'b1, stup = 1'b1;
   logic [1:0] sense = 2'b10;
   logic [3:0] pc = 4'h0, pmask = 4'h0;
   logic [7:0] oreq = 8'h00, acks, a0;
   vei_vec_t   vec, last_vec;
   int         errors = 0, n_compared = 0;
   always #5 clk = ~clk;
   vei_ctrl uut (.i_mclk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_ext_irq_pin(ext),
      .i_pin_change_inputs(pc), .i_sense_select_hi(sense[1]), .i_sense_select_lo(sense[0]),
      .i_ext_irq_mask(emask), .i_pin_change_enable(pcen), .i_pin_change_mask(pmask),
      .i_global_ie(gie), .i_ext_irq_flag_clr(eclr), .i_pin_change_flag_clr(pclr),
      .i_other_req(oreq), .i_any_reset(anyr), .i_vector_ack(ack), .i_sleeping(slp),
      .i_startup_done(stup), .o_irq_req(irq), .o_vector(vec), .o_ext_irq_flag(ef),
      .o_pin_change_flag(pf), .o_wake(wake));
   vei_core_model core (.i_mclk(clk), .i_ack_en(ack_en), .i_irq_req(irq), .i_vector(vec),
      .o_ack(ack), .o_last_vec(last_vec), .o_acks(acks));
   ////////////////////////////////////////////////////////////////////////////////
   task chk(input logic [3:0] seen, input logic [3:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task clr_flags;
      eclr = 1'b1;
      pclr = 1'b1;
      tick(1);
      eclr = 1'b0;
      pclr = 1'b0;
      tick(1);
   endtask
   task test_done;
      $display("errors=%0d compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task s_reset;
      chk(irq, 1'b0);
      gie = 1'b1;
      oreq = 8'h08;
      tick(2);
      chk(vec, `VEI_VEC_TCMPB);
      anyr = 1'b1;
      tick(2);
      chk(vec, `VEI_VEC_RESET);
      chk(irq, 1'b0);
      anyr = 1'b0;
      oreq = 8'h00;
   endtask
   task s_halt;
      ce = 1'b0;
      ext = 1'b0;
      tick(4);
      chk(ef, 1'b0);
      ext = 1'b1;
      ce = 1'b1;
      tick(6);
      chk(ef, 1'b0);
      chk(irq, 1'b0);
   endtask
   task s_vectors;
      gie = 1'b1;
      for (int i = 0; i < 8; i++) begin
         oreq = 8'h01 << i;
         tick(2);
         chk(irq, 1'b1);
         chk(vec, `VEI_VEC_TCAPT + 4'(i));
      end
      oreq = 8'hFF;
      tick(2);
      chk(vec, `VEI_VEC_TCAPT);
      oreq = 8'h00;
   endtask
   task s_ext;
      logic [1:0] m [3];
      m = '{2'b10, 2'b11, 2'b01};
      emask = 1'b1;
      for (int i = 0; i < 3; i++) begin
         sense = m[i];
         ext = ~(m[i][1] & m[i][0]);
         tick(8);
         clr_flags;
         chk(ef, 1'b0);
         ext = ~ext;
         tick(6);
         chk(ef, 1'b1);
         chk(vec, `VEI_VEC_EXT);
         clr_flags;
         ext = ~ext;
         tick(6);
         chk(ef, m[i] == 2'b01);
      end
      ack_en = 1'b1;
      tick(4);
      chk(ef, 1'b0);
      chk(last_vec, `VEI_VEC_EXT);
      ack_en = 1'b0;
   endtask
   task s_level;
      sense = 2'b00;
      ext = 1'b0;
      tick(6);
      chk(irq, 1'b1);
      chk(vec, `VEI_VEC_EXT);
      chk(ef, 1'b0);
      a0 = acks;
      ack_en = 1'b1;
      tick(12);
      ack_en = 1'b0;
      chk((acks - a0) > 8'h01, 1'b1);
      emask = 1'b0;
      tick(3);
      chk(irq, 1'b0);
      ext = 1'b1;
      emask = 1'b1;
   endtask
   task s_pchg;
      sense = 2'b10;
      pcen = 1'b1;
      pmask = 4'b0100;
      tick(8);
      clr_flags;
      pc = pc ^ 4'b0001;
      tick(8);
      chk(pf, 1'b0);
      pc = pc ^ 4'b0100;
      tick(8);
      chk(pf, 1'b1);
      chk(vec, `VEI_VEC_PCHG);
      ext = 1'b0;
      tick(6);
      chk(vec, `VEI_VEC_EXT);
      ext = 1'b1;
      clr_flags;
      pcen = 1'b0;
      pc = pc ^ 4'b0100;
      tick(8);
      chk(pf, 1'b1);
      chk(irq, 1'b0);
      pcen = 1'b1;
      clr_flags;
   endtask
   task s_sleep;
      slp = 1'b1;
      tick(2);
      pc = pc ^ 4'b0100;
      tick(2);
      chk(wake, 1'b1);
      tick(8);
      clr_flags;
      chk(wake, 1'b0);
      sense = 2'b00;
      ext = 1'b0;
      tick(1);
      chk(wake, 1'b1);
      tick(3);
      chk(irq, 1'b0);
      stup = 1'b0;
      slp = 1'b0;
      tick(3);
      chk(irq, 1'b0);
      ext = 1'b1;
      tick(2);
      stup = 1'b1;
      tick(6);
      chk(irq, 1'b0);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      tick(2);
      rst_n = 1'b1;
      tick(2);
      s_reset;
      s_vectors;
      s_ext;
      s_level;
      s_pchg;
      s_halt;
      s_sleep;
      test_done;
   end
   // run needs a few hundred cycles; this leaves a wide margin
   initial begin
      #20000;
      errors++;
      test_done;
   end
endmodule
